// ===== rtl/cpdg_top.sv
// command pulse decoder with electronic gear and axi4-lite settings
// Function
// - rotation setting 0 turns a positive command clockwise, 1 counterclockwise, negative opposite.
// - positive limit matters only for positive command, negative limit only for negative.
// - the command pulse train arrives on a pulse pair and a sign pair.
// - format 0 or 2 is quadrature, 1 is separate up/down trains, 3 is pulse plus sign.
// - counting direction 1 reverses the positive sense of every format.
// - the count moves only on the designated active edges, never on other transitions.
// - the counted pulses times the gear ratio form the position command.
// - a nonzero pulses-per-revolution value maps that many pulses to one revolution.
// - with pulses-per-revolution zero the ratio is numerator over denominator.
// - full-closed control ignores pulses-per-revolution and uses numerator over denominator.
// - the numerator accepts 0 to 2^30 and, when 0 in position control, becomes the resolution.
// - full-closed control with numerator 0 uses a ratio of one.
// - the denominator accepts 1 to 2^30 and never zero.
// - in position control, pulses-per-revolution and numerator both 0 give resolution over denominator.
`timescale 1ns/1ps
module cpdg_top import cpdg_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmd_pulse_in_pos,
	input wire logic cmd_pulse_in_neg,
	input wire logic cmd_dir_in_pos,
	input wire logic cmd_dir_in_neg,
	input wire logic overtravel_pos_in,
	input wire logic overtravel_neg_in,
	output logic [31:0] pos_cmd,
	output logic pos_cmd_valid,
	output logic motor_dir_ccw,
	output logic overtravel_stop
);
	// ****************************************
	// settings registers
	// ****************************************
	logic rotation_direction_setup;
	logic count_direction_setup;
	logic [1:0] input_format_setup;
	logic full_closed;
	logic count_clear;
	logic [GW-1:0] pulses_per_revolution;
	logic [GW-1:0] gear_numerator;
	logic [GW-1:0] gear_denominator;
	logic [GW-1:0] encoder_resolution;

	// ****************************************
	// pin synchronisation and decode
	// ****************************************
	logic [5:0] pins_s;
	logic pulse_lvl, sign_lvl, ot_pos, ot_neg;
	logic prev_pulse, prev_sign;
	logic raw_step, raw_up, step_up;
	logic signed [31:0] cmd_count;
	logic last_pos;

	cpdg_sync2 #(.W(6)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({overtravel_neg_in, overtravel_pos_in, cmd_dir_in_neg, cmd_dir_in_pos,
			cmd_pulse_in_neg, cmd_pulse_in_pos}),
		.q(pins_s)
	);

	// a pair reads high when its legs are driven apart in the positive sense
	assign pulse_lvl = pins_s[0] & ~pins_s[1];
	assign sign_lvl = pins_s[2] & ~pins_s[3];
	assign ot_pos = pins_s[4];
	assign ot_neg = pins_s[5];

	// previous levels for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_pulse <= 1'b0;
			prev_sign <= 1'b0;
		end else begin
			prev_pulse <= pulse_lvl;
			prev_sign <= sign_lvl;
		end
	end

	// format decode; only listed edges produce a step
	always_comb begin
		raw_step = 1'b0;
		raw_up = 1'b0;
		unique case (input_format_setup)
			FMT_QUAD_A, FMT_QUAD_B: begin
				// a change on both phases at once is ambiguous and is dropped
				if (pulse_lvl != prev_pulse && sign_lvl == prev_sign) begin
					raw_step = 1'b1;
					raw_up = (pulse_lvl == sign_lvl);
				end else if (sign_lvl != prev_sign && pulse_lvl == prev_pulse) begin
					raw_step = 1'b1;
					raw_up = (pulse_lvl != sign_lvl);
				end
			end
			FMT_POSNEG: begin
				// simultaneous rises cancel, so no step is issued
				if ((pulse_lvl & ~prev_pulse) != (sign_lvl & ~prev_sign)) begin
					raw_step = 1'b1;
					raw_up = pulse_lvl & ~prev_pulse;
				end
			end
			FMT_PLSIGN: begin
				if (pulse_lvl & ~prev_pulse) begin
					raw_step = 1'b1;
					raw_up = sign_lvl;
				end
			end
		endcase
	end

	assign step_up = raw_up ^ count_direction_setup;

	// command pulse counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_count <= 32'sh0;
		end else if (count_clear) begin
			cmd_count <= 32'sh0;
		end else if (raw_step) begin
			cmd_count <= step_up ? cmd_count + 32'sh1 : cmd_count - 32'sh1;
		end
	end

	// command direction, motor rotation and overtravel gating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_pos <= 1'b1;
			motor_dir_ccw <= 1'b0;
			overtravel_stop <= 1'b0;
		end else begin
			if (raw_step) begin
				last_pos <= step_up;
			end
			motor_dir_ccw <= last_pos ? rotation_direction_setup : ~rotation_direction_setup;
			overtravel_stop <= (last_pos & ot_pos) | (~last_pos & ot_neg);
		end
	end

	// ****************************************
	// gear ratio selection
	// ****************************************
	logic [GW-1:0] sel_num, sel_den;

	always_comb begin
		if (full_closed) begin
			sel_num = (gear_numerator == '0) ? UNITY : gear_numerator;
			sel_den = (gear_numerator == '0) ? UNITY : gear_denominator;
		end else if (pulses_per_revolution != '0) begin
			sel_num = encoder_resolution;
			sel_den = pulses_per_revolution;
		end else begin
			sel_num = (gear_numerator == '0) ? encoder_resolution : gear_numerator;
			sel_den = gear_denominator;
		end
	end

	// ****************************************
	// scaling: count * num / den, serial divide
	// ****************************************
	cpdg_div_e dv_state;
	logic [63:0] dvd;
	logic [31:0] rem;
	logic [GW-1:0] den_q;
	logic neg_q;
	logic [6:0] dv_cnt;
	logic [31:0] mag;
	logic [31:0] trial;

	// the whole count is rescaled each pass, so fractions never accumulate error
	assign mag = cmd_count[31] ? 32'(-cmd_count) : 32'(cmd_count);
	assign trial = {rem[30:0], dvd[63]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dv_state <= DV_IDLE;
			dvd <= 64'h0;
			rem <= 32'h0;
			den_q <= UNITY;
			neg_q <= 1'b0;
			dv_cnt <= 7'h0;
		end else begin
			unique case (dv_state)
				DV_IDLE: dv_state <= DV_LOAD;
				DV_LOAD: begin
					dvd <= 64'(mag * {1'b0, sel_num});
					den_q <= (sel_den == '0) ? UNITY : sel_den;
					neg_q <= cmd_count[31];
					rem <= 32'h0;
					dv_cnt <= 7'h0;
					dv_state <= DV_DIV;
				end
				DV_DIV: begin
					if (trial >= {1'b0, den_q}) begin
						rem <= trial - {1'b0, den_q};
						dvd <= {dvd[62:0], 1'b1};
					end else begin
						rem <= trial;
						dvd <= {dvd[62:0], 1'b0};
					end
					dv_cnt <= dv_cnt + 7'h1;
					if (dv_cnt == DIV_STEPS - 7'h1) begin
						dv_state <= DV_DONE;
					end
				end
				DV_DONE: dv_state <= DV_IDLE;
			endcase
		end
	end

	// position command to the position loop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_cmd <= 32'h0;
			pos_cmd_valid <= 1'b0;
		end else begin
			pos_cmd_valid <= (dv_state == DV_DONE);
			if (dv_state == DV_DONE) begin
				pos_cmd <= neg_q ? -dvd[31:0] : dvd[31:0];
			end
		end
	end

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	logic aw_go;
	logic [31:0] wval;
	logic [31:0] cur_w;
	logic w_ok;

	assign aw_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;

	// byte-lane merge of the write data onto the present contents
	always_comb begin
		unique case (s_axi_awaddr)
			ADDR_CTRL: cur_w = {26'h0, 1'b0, full_closed, input_format_setup,
				count_direction_setup, rotation_direction_setup};
			ADDR_PPR: cur_w = {1'b0, pulses_per_revolution};
			ADDR_GNUM: cur_w = {1'b0, gear_numerator};
			ADDR_GDEN: cur_w = {1'b0, gear_denominator};
			ADDR_ENCRES: cur_w = {1'b0, encoder_resolution};
			default: cur_w = 32'h0;
		endcase
		for (int i = 0; i < 4; i++) begin
			wval[i*8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : cur_w[i*8 +: 8];
		end
		// out-of-range settings are refused and leave the register as it was
		unique case (s_axi_awaddr)
			ADDR_CTRL, ADDR_ENCRES: w_ok = 1'b1;
			ADDR_PPR: w_ok = (wval <= {1'b0, PPR_MAX});
			ADDR_GNUM: w_ok = (wval <= {1'b0, GEAR_MAX});
			ADDR_GDEN: w_ok = (wval != 32'h0) && (wval <= {1'b0, GEAR_MAX});
			default: w_ok = 1'b0;
		endcase
	end

	// both channels are taken together, one cycle after both are offered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
			s_axi_wready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
			if (aw_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rotation_direction_setup <= 1'b0;
			count_direction_setup <= 1'b0;
			input_format_setup <= FMT_QUAD_A;
			full_closed <= 1'b0;
			count_clear <= 1'b0;
			pulses_per_revolution <= PPR_RST;
			gear_numerator <= GNUM_RST;
			gear_denominator <= GDEN_RST;
			encoder_resolution <= ENCRES_RST;
		end else begin
			count_clear <= aw_go & (s_axi_awaddr == ADDR_CTRL) & wval[CTRL_CLEAR];
			if (aw_go && w_ok) begin
				unique case (s_axi_awaddr)
					ADDR_CTRL: begin
						rotation_direction_setup <= wval[CTRL_ROT];
						count_direction_setup <= wval[CTRL_CNTDIR];
						input_format_setup <= wval[CTRL_FMT_LO +: 2];
						full_closed <= wval[CTRL_FULLCL];
					end
					ADDR_PPR: pulses_per_revolution <= wval[GW-1:0];
					ADDR_GNUM: gear_numerator <= wval[GW-1:0];
					ADDR_GDEN: gear_denominator <= wval[GW-1:0];
					ADDR_ENCRES: encoder_resolution <= wval[GW-1:0];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	logic [31:0] rd_mux;
	logic rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			ADDR_CTRL: rd_mux = {26'h0, 1'b0, full_closed, input_format_setup,
				count_direction_setup, rotation_direction_setup};
			ADDR_PPR: rd_mux = {1'b0, pulses_per_revolution};
			ADDR_GNUM: rd_mux = {1'b0, gear_numerator};
			ADDR_GDEN: rd_mux = {1'b0, gear_denominator};
			ADDR_ENCRES: rd_mux = {1'b0, encoder_resolution};
			ADDR_COUNT: rd_mux = cmd_count;
			ADDR_POSCMD: rd_mux = pos_cmd;
			ADDR_STAT: rd_mux = {28'h0, overtravel_stop, ot_neg, ot_pos, last_pos};
			default: begin
				rd_mux = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// address taken one cycle after it is offered, data registered at that same edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_ROT_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> motor_dir_ccw == ($past(last_pos) ^ ~$past(rotation_direction_setup)))
		else $error("motor rotation does not follow command direction");
	AST_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(last_pos) && !$past(ot_pos)) |-> !overtravel_stop)
		else $error("negative limit stopped a positive command");
	AST_NO_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
		(pulse_lvl == prev_pulse && sign_lvl == prev_sign && !count_clear)
		|=> cmd_count == $past(cmd_count))
		else $error("count moved without an active edge");
	AST_CNT_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
		(raw_step && !count_clear && (raw_up != count_direction_setup))
		|=> cmd_count == $past(cmd_count) + 32'sh1)
		else $error("count direction setting not applied");
	AST_QUAD: assert property (@(posedge aclk) disable iff (!aresetn)
		(input_format_setup == FMT_QUAD_A && !count_direction_setup && !prev_pulse
		&& !prev_sign && !pulse_lvl && sign_lvl) |-> raw_step && step_up)
		else $error("b leading a did not count up");
	AST_SIGN: assert property (@(posedge aclk) disable iff (!aresetn)
		(input_format_setup == FMT_PLSIGN && pulse_lvl && !prev_pulse)
		|-> raw_step && (step_up == (sign_lvl ^ count_direction_setup)))
		else $error("pulse plus sign direction wrong");
	AST_DEN_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
		gear_denominator != '0)
		else $error("denominator reached zero");
	AST_PPR_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		(!full_closed && pulses_per_revolution != '0)
		|-> sel_num == encoder_resolution && sel_den == pulses_per_revolution)
		else $error("pulses per revolution not used");
	AST_FC_UNITY: assert property (@(posedge aclk) disable iff (!aresetn)
		(full_closed && gear_numerator == '0) |-> sel_num == UNITY && sel_den == UNITY)
		else $error("full closed numerator zero not unity");
	AST_NUM0: assert property (@(posedge aclk) disable iff (!aresetn)
		(!full_closed && pulses_per_revolution == '0 && gear_numerator == '0)
		|-> sel_num == encoder_resolution && sel_den == gear_denominator)
		else $error("resolution over denominator not used");
	AST_DIV_TIME: assert property (@(posedge aclk) disable iff (!aresetn)
		(dv_state == DV_LOAD) |-> ##66 pos_cmd_valid)
		else $error("position command not produced in time");
endmodule : cpdg_top

// ===== shared/cpdg_pkg.sv
// constants for the command pulse decoder and electronic gear block
package cpdg_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PPR = 8'h04;
	localparam logic [7:0] ADDR_GNUM = 8'h08;
	localparam logic [7:0] ADDR_GDEN = 8'h0c;
	localparam logic [7:0] ADDR_ENCRES = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;
	localparam logic [7:0] ADDR_POSCMD = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1c;
	// ****************************************
	// control and status fields
	// ****************************************
	localparam int CTRL_ROT = 0;
	localparam int CTRL_CNTDIR = 1;
	localparam int CTRL_FMT_LO = 2;
	localparam int CTRL_FULLCL = 4;
	localparam int CTRL_CLEAR = 5;
	localparam int STAT_POSDIR = 0;
	localparam int STAT_OTPOS = 1;
	localparam int STAT_OTNEG = 2;
	localparam int STAT_OTSTOP = 3;
	// ****************************************
	// settings, limits and reset values
	// ****************************************
	localparam int GW = 31;
	localparam logic [1:0] FMT_QUAD_A = 2'h0;
	localparam logic [1:0] FMT_POSNEG = 2'h1;
	localparam logic [1:0] FMT_QUAD_B = 2'h2;
	localparam logic [1:0] FMT_PLSIGN = 2'h3;
	localparam logic [GW-1:0] PPR_MAX = 31'h00100000;
	localparam logic [GW-1:0] GEAR_MAX = 31'h40000000;
	localparam logic [GW-1:0] PPR_RST = 31'h00000000;
	localparam logic [GW-1:0] GNUM_RST = 31'h00000000;
	localparam logic [GW-1:0] GDEN_RST = 31'h00002710;
	localparam logic [GW-1:0] ENCRES_RST = 31'h00100000; // plain default, software sets it
	localparam logic [GW-1:0] UNITY = 31'h00000001;
	localparam logic [6:0] DIV_STEPS = 7'h40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// divider sequence, gray along the loop
	typedef enum logic [1:0] {
		DV_IDLE = 2'h0,
		DV_LOAD = 2'h1,
		DV_DIV = 2'h3,
		DV_DONE = 2'h2
	} cpdg_div_e;
endpackage : cpdg_pkg

// ===== rtl/cpdg_sync2.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cpdg_sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : cpdg_sync2

// ===== tb/cpdg_ctl_model.sv
// behavioural motion controller that sends command pulse trains
`timescale 1ns/1ps
module cpdg_ctl_model (
	input wire logic aclk,
	output logic pulse_pos,
	output logic pulse_neg,
	output logic dir_pos,
	output logic dir_neg
);
	logic a = 1'b0;
	logic b = 1'b0;
	logic [1:0] q = 2'h0;
	// each pair carries its level on one leg and the inverse on the other
	assign pulse_pos = a;
	assign pulse_neg = ~a;
	assign dir_pos = b;
	assign dir_neg = ~b;
	// change legs right after an edge, then rest; gap of 3 or more keeps edges apart
	task automatic put(input logic [1:0] ab, input int gap);
		@(posedge aclk);
		a <= ab[1];
		b <= ab[0];
		repeat (gap) @(posedge aclk);
	endtask : put
	// both pair levels low after a format change, so no stale level lingers
	task automatic park();
		q = 2'h0;
		put(2'h0, 3);
	endtask : park
	// one command unit in the chosen format, up means a positive command
	task automatic send(input logic [1:0] fmt, input logic up, input int gap);
		case (fmt)
			2'h1: begin // separate up and down trains
				put(up ? 2'h2 : 2'h1, gap);
				put(2'h0, gap);
			end
			2'h3: begin // sign settles before the pulse rises
				put({1'b0, up}, gap);
				put({1'b1, up}, gap);
				put({1'b0, up}, gap);
			end
			default: begin // quadrature, b leads a for up
				q = up ? q + 2'h1 : q - 2'h1;
				put({q[1], q[1] ^ q[0]}, gap);
			end
		endcase
	endtask : send
endmodule : cpdg_ctl_model

// ===== tb/tb_top.sv
// self-checking bench for the command pulse decoder and electronic gear
`timescale 1ns/1ps
module tb_top import cpdg_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic otp = 1'b0, otn = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pcv, ccw, ots, pp, pn, dp, dn;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, pcmd;
	int bad_count = 0;
	int n_compared = 0;
	logic [31:0] rs = 32'h1e;
	cpdg_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmd_pulse_in_pos(pp), .cmd_pulse_in_neg(pn),
		.cmd_dir_in_pos(dp), .cmd_dir_in_neg(dn), .overtravel_pos_in(otp),
		.overtravel_neg_in(otn), .pos_cmd(pcmd), .pos_cmd_valid(pcv),
		.motor_dir_ccw(ccw), .overtravel_stop(ots));
	cpdg_ctl_model ctl_u (.aclk(aclk), .pulse_pos(pp), .pulse_neg(pn), .dir_pos(dp),
		.dir_neg(dn));
	// 50 ns period
	initial begin
		forever #25 aclk = ~aclk;
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs
	// expected gear output, truncated toward zero like the design
	function automatic logic [31:0] exp_cmd(input longint c, input bit fc, input longint p,
		input longint nu, input longint de, input longint en);
		longint n;
		longint d;
		n = nu;
		d = de;
		if (fc && nu == 0) begin
			n = 1;
			d = 1;
		end else if (!fc && p != 0) begin
			n = en;
			d = p;
		end else if (!fc && nu == 0) begin
			n = en;
		end
		return 32'(c * n / d);
	endfunction : exp_cmd
	task automatic report_and_stop();
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// a wait that runs out ends the run as a failure
	task automatic give_up();
		bad_count++;
		report_and_stop();
	endtask : give_up
	// one write; address and data offered together, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
			if (n > 60) give_up();
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, e});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
			if (n > 60) give_up();
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, d);
		chk({30'h0, rresp}, {30'h0, e});
	endtask : rd
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] r, ctrl, ppr, num, den, ex;
		logic [1:0] fm;
		logic cd, rot, up, pos;
		bit fc;
		int k, cnt, n;
		pos = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(pcmd, 32'h0);
		chk({29'h0, pcv, ccw, ots}, 32'h0);
		rd(ADDR_CTRL, 32'h0, RESP_OKAY);
		rd(ADDR_PPR, {1'b0, PPR_RST}, RESP_OKAY);
		rd(ADDR_GNUM, {1'b0, GNUM_RST}, RESP_OKAY);
		rd(ADDR_GDEN, {1'b0, GDEN_RST}, RESP_OKAY);
		rd(ADDR_ENCRES, {1'b0, ENCRES_RST}, RESP_OKAY);
		rd(ADDR_STAT, 32'h1, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		// illegal settings are refused and leave the old value
		wr(ADDR_GDEN, 32'h0, RESP_SLVERR);
		wr(ADDR_GDEN, {1'b0, GEAR_MAX} + 32'h1, RESP_SLVERR);
		wr(ADDR_GNUM, {1'b0, GEAR_MAX} + 32'h1, RESP_SLVERR);
		wr(ADDR_PPR, {1'b0, PPR_MAX} + 32'h1, RESP_SLVERR);
		wr(ADDR_COUNT, 32'h5, RESP_SLVERR);
		wr(8'h20, 32'h5, RESP_SLVERR);
		rd(ADDR_GDEN, {1'b0, GDEN_RST}, RESP_OKAY);
		wr(ADDR_PPR, {1'b0, PPR_MAX}, RESP_OKAY);
		wr(ADDR_GNUM, {1'b0, GEAR_MAX}, RESP_OKAY);
		wr(ADDR_GDEN, {1'b0, GEAR_MAX}, RESP_OKAY);
		wr(ADDR_GDEN, 32'h1, RESP_OKAY);
		rd(ADDR_PPR, {1'b0, PPR_MAX}, RESP_OKAY);
		// every format with both counting senses, gear cases in turn
		for (int i = 0; i < 10; i++) begin
			r = xs();
			fm = 2'(i);
			cd = 1'(i >> 2);
			rot = r[0];
			k = i % 5;
			fc = (k == 2 || k == 4);
			ppr = (k == 0 || k == 2) ? (xs() % 32'h1000) + 32'h1 : 32'h0;
			num = (k >= 3) ? 32'h0 : (xs() % 32'h186a0) + 32'h1;
			den = (xs() % 32'h3e8) + 32'h1;
			wr(ADDR_PPR, ppr, RESP_OKAY);
			wr(ADDR_GNUM, num, RESP_OKAY);
			wr(ADDR_GDEN, den, RESP_OKAY);
			ctrl = {27'h0, fc, fm, cd, rot};
			wr(ADDR_CTRL, ctrl, RESP_OKAY);
			ctl_u.park();
			wr(ADDR_CTRL, ctrl | 32'h20, RESP_OKAY);
			cnt = 0;
			for (int j = 0; j < 8; j++) begin
				r = xs();
				up = r[0];
				ctl_u.send(fm, up, 3 + int'(r[2:1]));
				pos = up ^ cd;
				cnt = cnt + (pos ? 1 : -1);
			end
			repeat (10) @(posedge aclk);
			rd(ADDR_COUNT, 32'(cnt), RESP_OKAY);
			chk({31'h0, ccw}, {31'h0, rot ^ ~pos});
			r = xs();
			otp <= r[0];
			otn <= r[1];
			repeat (8) @(posedge aclk);
			chk({31'h0, ots}, {31'h0, pos ? r[0] : r[1]});
			repeat (150) @(posedge aclk);
			ex = exp_cmd(cnt, fc, ppr, num, den, ENCRES_RST);
			chk(pcmd, ex);
			// the valid pulse stands one cycle only, so catch it at the edge it is seen
			n = 0;
			while (pcv !== 1'b1) begin
				@(posedge aclk);
				n++;
				if (n > 70) give_up();
			end
			chk(pcmd, ex);
			rd(ADDR_POSCMD, ex, RESP_OKAY);
		end
		// reset in mid-run brings the settings and the count back to their reset values
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({29'h0, pcv, ccw, ots}, 32'h0);
		rd(ADDR_CTRL, 32'h0, RESP_OKAY);
		rd(ADDR_GDEN, {1'b0, GDEN_RST}, RESP_OKAY);
		rd(ADDR_COUNT, 32'h0, RESP_OKAY);
		report_and_stop();
	end
endmodule : tb_top
